// file: design/adc_link_pkg.sv
// Shared constants for the two-wire converter link, both ends
// Summary of operation
// [R1] Conversion lasts 8.96 us, self-timed, not by SCL
// [R2] Acquisition lasts 1.12 us on internal timer
// [R3] Single read: start, address, two bytes, stop
// [R4] Master acknowledge after result starts next conversion
// [R5] Master starts only while bus idle
// [R6] SDA stable while SCL high, else start/stop
// [R7] Start is SDA falling while SCL high
// [R8] Stop is SDA rising while SCL high
// [R9] One SCL pulse per bit, change when low
// [R10] Master decides byte count, device sets no limit
// [R11] Receiver acknowledges every byte on ninth clock
// [R12] Acknowledger holds SDA low through ack high
// [R13] Master not-acknowledges last byte, device releases SDA
// [R14] Device is slave; master makes clock and conditions
// [R15] Address byte: 4-bit code then three option bits
// [R16] Respond only if option bits match, default 101
// [R17] Eighth address bit: 1 read, 0 write
// [R18] Write address: acknowledge, release, no conversion
// [R19] Master ends communication with a stop
// [R20] Conversion starts at falling SCL of read bit
// [R21] Send 0000 plus upper four, then lower six, two spare
// [R22] Next sample starts at falling SCL of last lower bit
// [R23] Result straight binary, most significant bit first
// [R24] Mismatch releases SDA till start; start restarts address
package adc_link_pkg;
  localparam int          CLK_MHZ             = 125;
  localparam int          ACQ_NS              = 1120;  // acquisition_duration
  localparam int          CONV_NS             = 8960;  // conversion_duration
  localparam int          ACQ_CYCLES          = (ACQ_NS * CLK_MHZ) / 1000;
  localparam int          CONV_CYCLES         = (CONV_NS * CLK_MHZ) / 1000;
  localparam int          RESULT_BITS         = 10;
  localparam logic [3:0]  DEVICE_CODE         = 4'h6;  // Arbitrary device code value
  localparam logic [2:0]  DEFAULT_OPTION      = 3'h5;
  localparam logic        DIR_READ            = 1'b1;
  localparam logic        ACK_LEVEL           = 1'b0;
  localparam logic [3:0]  BIT_LAST            = 4'h7;
  localparam logic [3:0]  BIT_ACK             = 4'h8;
  localparam int          SCL_HALF_DEFAULT    = 10;    // ref_clk cycles per SCL quarter period
endpackage

// file: design/adc_link_if.sv
// Two-wire link between the bus master and the converter slave
interface adc_link_if;
  logic scl_o;      // Master clock drive low
  logic scl_oe;
  logic sda_m_o;
  logic sda_m_oe;
  logic sda_s_o;
  logic sda_s_oe;
  // Open-drain resolution with pull-ups
  wire  scl = !(scl_oe && !scl_o);
  wire  sda = !((sda_m_oe && !sda_m_o) || (sda_s_oe && !sda_s_o));
  modport master (output scl_o, scl_oe, sda_m_o, sda_m_oe, input scl, sda);
  modport slave  (output sda_s_o, sda_s_oe, input scl, sda);
endinterface

// file: design/adc_two_wire_read_slave.sv
// Converter slave end: address decode, self-timed conversion, result shift-out
module adc_two_wire_read_slave
  import adc_link_pkg::*;
#(
  parameter logic [2:0] OPTION = DEFAULT_OPTION
) (
  input  wire logic       ref_clk,
  input  wire logic       rstn,
  adc_link_if.slave       link,
  input  wire logic [9:0] sample_value,
  output logic            conv_busy,
  output logic [9:0]      last_result
);
  // Bit-level protocol states, one-hot
  typedef enum logic [4:0] {
    IDLE = 5'h01,  // Released, waiting for a start
    ADDR = 5'h02,  // Shifting in the address byte
    ACKA = 5'h04,  // Address acknowledge slot
    SEND = 5'h08,  // Shifting out a result byte
    RACK = 5'h10   // Master acknowledge slot after a result byte
  } st_type;
  // Converter timing states, one-hot
  typedef enum logic [2:0] {
    C_IDLE = 3'h1,  // Holding the last result
    C_ACQ  = 3'h2,  // Sampling capacitor acquiring
    C_CONV = 3'h4   // Successive approximation running
  } cv_type;

  logic [1:0]  scl_s;
  logic [1:0]  sda_s;
  logic        scl_d;
  logic        sda_d;
  st_type      st;
  cv_type      cv;
  logic [3:0]  bitn;
  logic [7:0]  shreg;
  logic        hi_byte;
  logic        read_op;
  logic        sda_hold;
  logic        pre_bit;  // Set from a start until its own SCL fall
  logic [15:0] cnt;
  logic [9:0]  result;
  logic [9:0]  tx_word;  // Result frozen for both bytes of one pair

  // Byte framing: upper byte leads with four zeros, lower ends with two spare bits
  function automatic logic [7:0] frame_byte(input logic [9:0] word, input logic upper);
    frame_byte = upper ? {4'h0, word[9:6]} : {word[5:0], 2'h0};
  endfunction

  // Two-flop synchronisers on both pins, then a registered copy for edges
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      scl_s <= 2'h3;
      sda_s <= 2'h3;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_s <= {scl_s[0], link.scl};
      sda_s <= {sda_s[0], link.sda};
      scl_d <= scl_s[1];
      sda_d <= sda_s[1];
    end
  end

  // Edge and condition decode on the synchronised pins
  wire scl_rise  = scl_s[1] && !scl_d;                     // see [R9]
  wire scl_fall  = !scl_s[1] && scl_d;
  wire start_det = scl_s[1] && scl_d && sda_d && !sda_s[1]; // see [R7] see [R6]
  wire stop_det  = scl_s[1] && scl_d && !sda_d && sda_s[1]; // see [R8] see [R6]
  wire addr_hit  = shreg[7:4] == DEVICE_CODE && shreg[3:1] == OPTION; // see [R15] see [R16]
  wire read_bit  = shreg[0] == DIR_READ;                   // see [R17]
  // The SCL fall that closes a start is not the end of a bit
  wire bit_fall  = scl_fall && !pre_bit;
  wire got_byte  = bit_fall && bitn == BIT_LAST;
  wire ack_fall  = scl_fall && bitn == BIT_ACK;
  // Upper byte from the live result, lower byte from the copy taken with it
  wire [7:0] hi_byte_val = frame_byte(result, 1'b1);       // see [R21] see [R23]
  wire [7:0] lo_byte_val = frame_byte(tx_word, 1'b0);
  // Conversion kick: read bit falling edge, or last lower bit in a stream
  wire kick = (st == ADDR && got_byte && addr_hit && shreg[0] == DIR_READ)  // see [R20]
           || (st == SEND && !hi_byte && got_byte);                          // see [R22] see [R4]

  // Bit-level protocol engine; slave only, never drives SCL
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      st       <= IDLE;
      bitn     <= 4'h0;
      shreg    <= 8'h00;
      hi_byte  <= 1'b1;
      read_op  <= 1'b0;
      sda_hold <= 1'b1;
      pre_bit  <= 1'b0;
      tx_word  <= 10'h000;
      // A start or a stop overrides whatever the bit engine was doing
    end else if (start_det) begin                          // see [R24]
      st       <= ADDR;
      bitn     <= 4'h0;
      pre_bit  <= 1'b1;
      sda_hold <= 1'b1;
    end else if (stop_det) begin
      st       <= IDLE;
      sda_hold <= 1'b1;
    end else begin
      unique case (st)
        IDLE: sda_hold <= 1'b1;                            // see [R24]
        ADDR: begin
          if (scl_rise) shreg <= {shreg[6:0], sda_s[1]};
          if (scl_fall) pre_bit <= 1'b0;
          if (bit_fall) bitn <= bitn + 4'h1;
          if (got_byte) begin
            if (addr_hit) begin
              st       <= ACKA;
              read_op  <= read_bit;
              sda_hold <= ACK_LEVEL;                       // see [R11] see [R12]
            end else begin
              st <= IDLE;                                  // see [R24]
            end
          end
        end
        ACKA: if (ack_fall) begin
          bitn <= 4'h0;
          if (read_op) begin
            st       <= SEND;
            hi_byte  <= 1'b1;
            tx_word  <= result;
            shreg    <= {hi_byte_val[6:0], 1'b0};
            sda_hold <= hi_byte_val[7];
          end else begin
            st       <= IDLE;                              // see [R18]
            sda_hold <= 1'b1;
          end
        end else if (scl_fall) begin
          bitn <= bitn + 4'h1;
        end
        SEND: if (scl_fall) begin
          bitn <= bitn + 4'h1;
          if (bitn == BIT_LAST) begin
            st       <= RACK;
            sda_hold <= 1'b1;                              // release for master ack
          end else begin
            sda_hold <= shreg[7];
            shreg    <= {shreg[6:0], 1'b0};
          end
        end
        RACK: begin
          if (scl_rise) read_op <= (sda_s[1] == ACK_LEVEL);
          if (ack_fall) begin
            bitn <= 4'h0;
            if (read_op) begin                             // see [R4] see [R10]
              st       <= SEND;
              hi_byte  <= !hi_byte;
              if (!hi_byte) tx_word <= result;             // see [R3] one word per byte pair
              shreg    <= hi_byte ? {lo_byte_val[6:0], 1'b0} : {hi_byte_val[6:0], 1'b0};
              sda_hold <= hi_byte ? lo_byte_val[7] : hi_byte_val[7];
            end else begin
              st       <= IDLE;                            // see [R13]
              sda_hold <= 1'b1;
            end
          end
        end
      endcase
    end
  end

  // Self-timed acquisition then conversion, independent of SCL
  // A kick while busy is dropped; reads meanwhile return the previous result
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cv          <= C_IDLE;
      cnt         <= 16'h0000;
      result      <= 10'h000;
      conv_busy   <= 1'b0;
      last_result <= 10'h000;
    end else begin
      unique case (cv)
        C_IDLE: if (kick) begin
          cv        <= C_ACQ;
          cnt       <= 16'(ACQ_CYCLES - 1);
          conv_busy <= 1'b1;
        end
        C_ACQ: if (cnt == 16'h0000) begin                  // see [R2]
          cv  <= C_CONV;
          cnt <= 16'(CONV_CYCLES - 1);
        end else cnt <= cnt - 16'h0001;
        C_CONV: if (cnt == 16'h0000) begin                 // see [R1]
          cv          <= C_IDLE;
          result      <= sample_value;
          last_result <= sample_value;
          conv_busy   <= 1'b0;
        end else cnt <= cnt - 16'h0001;
        default: cv <= C_IDLE;
      endcase
    end
  end

  // Open-drain drive: enable only when pulling low
  // Registered, so SDA moves a full cycle after the engine decides
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      link.sda_s_o  <= 1'b1;
      link.sda_s_oe <= 1'b0;
    end else begin
      link.sda_s_o  <= 1'b0;
      link.sda_s_oe <= !sda_hold;  // see [R14]
    end
  end
endmodule // adc_two_wire_read_slave

// file: design/adc_read_master.sv
// Bus master end: issues polls or reads of a requested number of results
module adc_read_master
  import adc_link_pkg::*;
#(
  parameter int HALF = SCL_HALF_DEFAULT
) (
  input  wire logic       ref_clk,
  input  wire logic       rstn,
  adc_link_if.master      link,
  input  wire logic       go,
  input  wire logic [2:0] option,
  input  wire logic       rd,
  input  wire logic [7:0] nresults,
  output logic            busy,
  output logic            res_valid,
  output logic [9:0]      res_data,
  output logic            nak_seen
);
  // Elaboration check: quarter-bit counter is eight bits, edges need four cycles
  if (HALF < 4 || HALF > 255) begin : g_half_bad
    $error("HALF out of range");
  end
  typedef enum logic [5:0] {
    M_IDLE = 6'h01, M_START = 6'h02, M_BITS = 6'h04, M_ACK = 6'h08, M_STOP = 6'h10, M_DONE = 6'h20
  } ms_type;
  ms_type     st;
  logic [7:0] tick;
  logic [1:0] ph;
  logic [3:0] bitn;
  logic [7:0] shreg;
  logic       addr_phase, hi, rd_r;
  logic [7:0] left;
  logic [3:0] upper;
  logic [1:0] sda_s;

  // Two-flop synchroniser on SDA
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) sda_s <= 2'h3;
    else       sda_s <= {sda_s[0], link.sda};
  end
  wire step = tick == 8'(HALF - 1);
  wire last = left == 8'h01;

  // Sequencer: four quarter phases per bit, SCL high in phases 2,3
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      st <= M_IDLE; tick <= 8'h00; ph <= 2'h0; bitn <= 4'h0; shreg <= 8'h00;
      addr_phase <= 1'b1; hi <= 1'b1; rd_r <= 1'b0; left <= 8'h00; upper <= 4'h0;
      busy <= 1'b0; res_valid <= 1'b0; res_data <= 10'h000; nak_seen <= 1'b0;
      link.scl_o <= 1'b1; link.scl_oe <= 1'b0; link.sda_m_o <= 1'b1; link.sda_m_oe <= 1'b0;
    end else begin
      res_valid <= 1'b0;
      tick <= step ? 8'h00 : tick + 8'h01;
      if (step) ph <= ph + 2'h1;
      unique case (st)
        M_IDLE: begin
          tick <= 8'h00; ph <= 2'h0;
          if (go && sda_s[1]) begin                        // see [R5]
            st <= M_START; busy <= 1'b1; nak_seen <= 1'b0;
            shreg <= {DEVICE_CODE, option, rd}; rd_r <= rd; // see [R17]
            left <= nresults; addr_phase <= 1'b1; hi <= 1'b1; bitn <= 4'h0;
            link.sda_m_oe <= 1'b1; link.sda_m_o <= 1'b0;   // see [R7]
          end
        end
        M_START: if (step && ph == 2'h1) begin
          link.scl_oe <= 1'b1; link.scl_o <= 1'b0; st <= M_BITS; ph <= 2'h0; // see [R14]
        end
        M_BITS: if (step) begin
          if (ph == 2'h0) begin                            // see [R9]
            link.sda_m_oe <= addr_phase ? !shreg[7] : 1'b0;
            link.sda_m_o  <= 1'b0;
          end
          if (ph == 2'h1) link.scl_oe <= 1'b0;
          if (ph == 2'h2) shreg <= {shreg[6:0], sda_s[1]};
          if (ph == 2'h3) begin
            link.scl_oe <= 1'b1;
            bitn <= bitn + 4'h1;
            if (bitn == BIT_LAST) st <= M_ACK;
          end
        end
        M_ACK: if (step) begin
          if (ph == 2'h0) begin                            // see [R11] see [R13]
            link.sda_m_oe <= !addr_phase && (hi || !last);  // Not-acknowledge only the last lower byte
            link.sda_m_o  <= 1'b0;
          end
          if (ph == 2'h1) link.scl_oe <= 1'b0;
          if (ph == 2'h2 && addr_phase && sda_s[1]) nak_seen <= 1'b1;
          if (ph == 2'h3) begin
            link.scl_oe <= 1'b1; bitn <= 4'h0;
            if (!addr_phase) begin
              if (hi) upper <= shreg[3:0];
              else begin
                res_valid <= 1'b1; res_data <= {upper, shreg[7:2]}; // see [R21] see [R23]
                left <= left - 8'h01;
              end
              hi <= !hi;
            end
            addr_phase <= 1'b0;
            if ((addr_phase && (!rd_r || nak_seen || left == 8'h00)) || (!addr_phase && !hi && last))
              st <= M_STOP;                                // see [R10] see [R19]
            else st <= M_BITS;                             // see [R4]
          end
        end
        M_STOP: if (step) begin                            // see [R8]
          if (ph == 2'h0) begin link.sda_m_oe <= 1'b1; link.sda_m_o <= 1'b0; end
          if (ph == 2'h1) link.scl_oe <= 1'b0;
          if (ph == 2'h3) begin link.sda_m_oe <= 1'b0; st <= M_DONE; end
        end
        M_DONE: if (step) begin busy <= 1'b0; st <= M_IDLE; end
        default: st <= M_IDLE;
      endcase
    end
  end
endmodule // adc_read_master

// file: sim/adc_link_chk.sv
// Protocol checker on the two-wire link between read master and converter slave
module adc_link_chk
  import adc_link_pkg::*;
#(
  parameter logic [2:0] OPTION = DEFAULT_OPTION,
  parameter int         HALF   = SCL_HALF_DEFAULT
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic sda_m_oe,
  input wire logic sda_s_oe,
  input wire logic scl,
  input wire logic sda
);
  logic        scl_q;
  logic        sda_q;
  logic [3:0]  bitn;
  logic [7:0]  nbyte;
  logic [7:0]  addr;
  logic [15:0] hi_cnt;
  // Edge and condition decode on the resolved lines
  wire         rise   = scl && !scl_q;
  wire         start  = scl && scl_q && sda_q && !sda;
  wire         hit    = addr[7:1] == {DEVICE_CODE, OPTION};
  wire         rd_hit = hit && addr[0];
  // Line history, bit slot, byte count and address capture
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      scl_q  <= 1'b1;
      sda_q  <= 1'b1;
      bitn   <= 4'h0;
      nbyte  <= 8'h00;
      addr   <= 8'h00;
      hi_cnt <= 16'h0000;
    end else begin
      scl_q  <= scl;
      sda_q  <= sda;
      hi_cnt <= !scl ? 16'h0000 : (&hi_cnt ? hi_cnt : hi_cnt + 16'h0001);
      if (start) begin
        bitn  <= 4'h0;
        nbyte <= 8'h00;
      end else if (rise) begin
        bitn <= (bitn == BIT_ACK) ? 4'h0 : bitn + 4'h1;
        if (bitn == BIT_ACK && nbyte != 8'hff) nbyte <= nbyte + 8'h01;
        if (nbyte == 8'h00 && bitn <= BIT_LAST) addr <= {addr[6:0], sda};
      end
    end
  end
  default clocking dcb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  sequence s_start; scl && $past(scl) && $fell(sda); endsequence
  sequence s_ack_slot; rise && bitn == BIT_ACK; endsequence
  property p_slave_edge; $changed(sda_s_oe) |-> !scl; endproperty
  property p_scl_wide; $fell(scl) |-> hi_cnt >= 16'(2 * HALF); endproperty
  property p_start_clock; s_start |-> ##[1:64] $fell(scl); endproperty
  property p_start_idle; $rose(sda_m_oe) && scl |-> !sda_s_oe; endproperty
  property p_addr_ack; s_ack_slot ##0 (nbyte == 8'h00 && hit) |-> !sda; endproperty
  property p_miss_quiet; s_ack_slot ##0 (nbyte == 8'h00 && !hit) |-> !sda_s_oe; endproperty
  property p_high_zeros; rise && nbyte[0] && bitn < 4'h4 && rd_hit |-> !sda; endproperty
  property p_poll_free; rise && nbyte != 8'h00 && hit && !addr[0] |-> !sda_s_oe; endproperty
  property p_master_ack; s_ack_slot ##0 (nbyte != 8'h00 && rd_hit) |-> !sda_s_oe; endproperty
  a_slave_edge: assert property (p_slave_edge) else $error("slave moved SDA with SCL high");
  a_scl_wide: assert property (p_scl_wide) else $error("SCL high phase too short");
  a_start_clock: assert property (p_start_clock) else $error("no clock after start");
  a_start_idle: assert property (p_start_idle) else $error("start on busy bus");
  a_addr_ack: assert property (p_addr_ack) else $error("address not acknowledged");
  a_miss_quiet: assert property (p_miss_quiet) else $error("slave drove on foreign address");
  a_high_zeros: assert property (p_high_zeros) else $error("upper byte lead bits not zero");
  a_poll_free: assert property (p_poll_free) else $error("slave held bus after poll");
  a_master_ack: assert property (p_master_ack) else $error("slave drove in master ack slot");
endmodule // adc_link_chk

// file: sim/tb.sv
// Bench joining the read master and the converter slave across the link
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import adc_link_pkg::*;
  localparam int HALF = 4;
  logic       ref_clk      = 1'b0;
  logic       rstn         = 1'b0;
  logic       go           = 1'b0;
  logic [2:0] option       = DEFAULT_OPTION;
  logic       rd           = 1'b1;
  logic [7:0] nresults     = 8'h01;
  logic [9:0] sample_value = 10'h000;
  logic       busy;
  logic       res_valid;
  logic       nak_seen;
  logic       conv_busy;
  logic [9:0] res_data;
  logic [9:0] last_result;
  logic [9:0] got;
  int         errors       = 0;
  int         n_tests      = 0;
  int         nres;
  int         nconv;
  int         len;
  adc_link_if i_adc_link_if ();
  adc_read_master #(.HALF(HALF)) i_adc_read_master (
    .ref_clk(ref_clk), .rstn(rstn), .link(i_adc_link_if.master), .go(go), .option(option), .rd(rd),
    .nresults(nresults), .busy(busy), .res_valid(res_valid), .res_data(res_data), .nak_seen(nak_seen));
  adc_two_wire_read_slave i_adc_two_wire_read_slave (
    .ref_clk(ref_clk), .rstn(rstn), .link(i_adc_link_if.slave), .sample_value(sample_value),
    .conv_busy(conv_busy), .last_result(last_result));
  adc_link_chk #(.OPTION(DEFAULT_OPTION), .HALF(HALF)) i_adc_link_chk (
    .ref_clk(ref_clk), .rstn(rstn), .sda_m_oe(i_adc_link_if.sda_m_oe), .sda_s_oe(i_adc_link_if.sda_s_oe),
    .scl(i_adc_link_if.scl), .sda(i_adc_link_if.sda));
  // Reference clock
  initial begin
    forever #4 ref_clk = ~ref_clk;
  end
  // Verdict and end of run
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // One comparison
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] seen);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One master transaction, counting results and conversion cycles
  task automatic op(input logic [2:0] opt, input logic r, input logic [7:0] n);
    int k;
    option = opt;
    rd = r;
    nresults = n;
    nres = 0;
    nconv = 0;
    k = 0;
    go = 1'b1;
    @(negedge ref_clk);
    go = 1'b0;
    while (busy !== 1'b1 && k < 20) begin
      @(negedge ref_clk);
      k++;
    end
    if (busy !== 1'b1) begin
      check("op busy", 16'h0001, 16'(busy));
      wrap_up();
    end
    while (busy !== 1'b0 && k < 30000) begin
      @(negedge ref_clk);
      k++;
      if (res_valid === 1'b1) begin
        nres++;
        got = res_data;
      end
      if (conv_busy === 1'b1) nconv++;
    end
    if (k >= 30000) begin
      errors++;
      wrap_up();
    end
  endtask
  // Wait out a running conversion
  task automatic settle();
    len = 0;
    while (conv_busy === 1'b1 && len < 5000) begin
      @(negedge ref_clk);
      len++;
    end
    if (len >= 5000) begin
      errors++;
      wrap_up();
    end
  endtask
  // Single reads: each read returns the result of the conversion before it
  task automatic t_convert();
    logic [9:0] vals [3] = '{10'h3ff, 10'h000, 10'h2c9};
    logic [9:0] prev = 10'h000;
    foreach (vals[i]) begin
      sample_value = vals[i];
      op(DEFAULT_OPTION, 1'b1, 8'h01);
      check("results", 16'h0001, 16'(nres));
      check("stale data", 16'(prev), 16'(got));
      settle();
      check("conv cycles", 16'(ACQ_CYCLES + CONV_CYCLES), 16'(nconv + len - 1));
      check("last result", 16'(vals[i]), 16'(last_result));
      op(DEFAULT_OPTION, 1'b1, 8'h01);
      check("read data", 16'(vals[i]), 16'(got));
      settle();
      prev = vals[i];
    end
    $display("test convert done");
  endtask
  // Six results at HALF 4: the fifth lower byte restarts the idle converter, the sixth is fresh
  task automatic t_burst();
    sample_value = 10'h155;
    op(DEFAULT_OPTION, 1'b1, 8'h06);
    check("burst results", 16'h0006, 16'(nres));
    check("burst nak", 16'h0000, 16'(nak_seen));
    check("burst data", 16'h0155, 16'(got));
    settle();
    check("burst conv cycles", 16'(2 * (ACQ_CYCLES + CONV_CYCLES)), 16'(nconv + len - 1));
    check("burst result", 16'h0155, 16'(last_result));
    $display("test burst done");
  endtask
  // Polls at every option, a foreign read, then recovery
  task automatic t_poll();
    for (int o = 0; o < 8; o++) begin
      op(3'(o), 1'b0, 8'h00);
      check("poll nak", 16'(o != DEFAULT_OPTION), 16'(nak_seen));
      check("poll conversion", 16'h0000, 16'(nconv));
    end
    op(3'h4, 1'b1, 8'h02);
    check("miss results", 16'h0000, 16'(nres));
    check("miss conversion", 16'h0000, 16'(nconv));
    op(DEFAULT_OPTION, 1'b1, 8'h01);
    check("read after miss", 16'h0001, 16'(nres));
    settle();
    $display("test poll done");
  endtask
  // Reset, then the scenarios
  initial begin
    repeat (10) @(negedge ref_clk);
    rstn = 1'b1;
    @(negedge ref_clk);
    t_convert();
    t_burst();
    t_poll();
    wrap_up();
  end
endmodule // tb
